// ===== logic/wwd_pkg.sv
package wwd_pkg;

   // counter and prescaler widths
   localparam int unsigned CNT_W   = 32;
   localparam int unsigned PRE_W   = 8;
   localparam int unsigned PRE_SEL_W = 3;

   // reset values of the counter and the prescaler divider
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
   localparam logic [PRE_W-1:0] PRE_RST = 8'h00;

   // synchroniser depth for the service strobe pin
   localparam int unsigned SYNC_STAGES = 2;

   // configuration carried as one bundle
   typedef struct packed {
      logic                 enable;
      logic                 win_enable;
      logic                 irq_en;
      logic                 rst_en;
      logic [PRE_SEL_W-1:0] pre_sel;
      logic [CNT_W-1:0]     timeout;
      logic [CNT_W-1:0]     win_open;
   } wwd_cfg_s;

   // timeout responses leaving the block
   typedef struct packed {
      logic irq;
      logic sys_rst;
      logic wake;
   } wwd_resp_s;

   typedef enum logic [1:0] {
      WWD_OFF,
      WWD_RUN,
      WWD_FIRED
   } wwd_state_e;

endpackage

// ===== logic/wwd_prescaler.sv
`timescale 1ns/1ps
module wwd_prescaler
   import wwd_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 run_i,
   input  wire logic [PRE_SEL_W-1:0] sel_i,
   output logic                      tick_o
);

   typedef struct packed {
      logic [PRE_W-1:0] div;
   } wwd_pre_s;

   wwd_pre_s st_q;
   wwd_pre_s st_d;

   // tick when the low sel bits of the divider are all ones: divide by 2**sel
   function automatic logic tick_of(input logic [PRE_W-1:0] v, input logic [PRE_SEL_W-1:0] s);
      logic [PRE_W-1:0] m;
      m = PRE_W'((9'h001 << s) - 9'h001);
      return (v & m) == m;
   endfunction

   always_comb begin
      st_d = st_q;
      if (!run_i) begin
         st_d.div = PRE_RST;
      end else begin
         st_d.div = st_q.div + 8'h01;
      end
   end

   assign tick_o = run_i && tick_of(st_q.div, sel_i);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

// ===== logic/wwd_top.sv
`timescale 1ns/1ps
// Contract
// - A 32-bit counter runs freely while enabled and advances on ticks of a prescaler with selectable division.
// - A count that reaches the timeout without service declares a timeout event.
// - A timeout raises the configured responses: interrupt request, system reset request, or both.
// - Either response steers execution back to a known good location.
// - With windowing on, a service counts only inside the configured window.
// - A watchdog interrupt can wake the device from the coprocessor low-power mode.
// - The low-power instance can wake the device from micro-power mode.
module wwd_top
   import wwd_pkg::*;
#(
   parameter bit LOW_POWER_INST = 1'b0
)
(
   input  wire logic      clk_i,
   input  wire logic      arst_n_i,
   input  wire wwd_cfg_s  cfg_i,
   input  wire logic      service_i,
   input  wire logic      irq_clr_i,
   input  wire logic      lpm_i,
   input  wire logic      upm_i,
   output logic           irq_o,
   output logic           sys_rst_o,
   output logic           wake_o,
   output logic           restart_o,
   output logic           early_o,
   output logic [CNT_W-1:0] count_o
);

   // reset release through two flops
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   typedef struct packed {
      logic [SYNC_STAGES-1:0] svc_sync;
      logic                   svc_last;
      wwd_state_e             state;
      logic [CNT_W-1:0]       count;
      wwd_resp_s              resp;
      logic                   restart;
      logic                   early;
   } wwd_st_s;

   wwd_st_s st_q;
   wwd_st_s st_d;
   logic    tick;
   logic    svc_pulse;
   logic    expired;
   logic    too_early;
   logic    asleep;

   // prescaler, kept counting only while the watchdog runs
   wwd_prescaler u_pre (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .run_i   (st_q.state == WWD_RUN),
      .sel_i   (cfg_i.pre_sel),
      .tick_o  (tick)
   );

   // service strobe comes from a pin: only the second stage is looked at
   assign svc_pulse = st_q.svc_sync[SYNC_STAGES-1] && !st_q.svc_last;
   assign expired   = st_q.count >= cfg_i.timeout;
   assign too_early = cfg_i.win_enable && st_q.count < cfg_i.win_open;
   // primary instance wakes only from lpm; low-power instance also from upm
   assign asleep    = lpm_i || (LOW_POWER_INST && upm_i);

   always_comb begin
      st_d          = st_q;
      st_d.svc_sync = {st_q.svc_sync[SYNC_STAGES-2:0], service_i};
      st_d.svc_last = st_q.svc_sync[SYNC_STAGES-1];
      st_d.restart  = 1'b0;
      st_d.early    = 1'b0;
      st_d.resp.sys_rst = 1'b0;
      // interrupt is sticky: a new timeout beats a same-cycle clear
      if (irq_clr_i) begin
         st_d.resp.irq = 1'b0;
      end
      unique case (st_q.state)
         WWD_OFF: begin
            st_d.count = CNT_RST;
            if (cfg_i.enable) begin
               st_d.state = WWD_RUN;
            end
         end
         WWD_RUN: begin
            if (!cfg_i.enable) begin
               st_d.state = WWD_OFF;
            end else if (svc_pulse && too_early) begin
               st_d.early = 1'b1;
               st_d.state = WWD_FIRED;
            end else if (svc_pulse) begin
               st_d.count = CNT_RST;
            end else if (expired) begin
               st_d.state = WWD_FIRED;
            end else if (tick) begin
               st_d.count = st_q.count + 32'h0000_0001;
            end
         end
         WWD_FIRED: begin
            // one-shot reset request and restart, sticky interrupt, then start counting afresh
            st_d.resp.irq     = st_d.resp.irq | cfg_i.irq_en;
            st_d.resp.sys_rst = cfg_i.rst_en;
            st_d.restart      = cfg_i.irq_en | cfg_i.rst_en;
            st_d.count        = CNT_RST;
            st_d.state        = cfg_i.enable ? WWD_RUN : WWD_OFF;
         end
      endcase
      st_d.resp.wake = st_d.resp.irq && asleep;
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '{svc_sync: '0, svc_last: 1'b0, state: WWD_OFF, count: CNT_RST,
                   resp: '0, restart: 1'b0, early: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign irq_o     = st_q.resp.irq;
   assign sys_rst_o = st_q.resp.sys_rst;
   assign wake_o    = st_q.resp.wake;
   assign restart_o = st_q.restart;
   assign early_o   = st_q.early;
   assign count_o   = st_q.count;

   // assertions
   property p_expire;
      @(posedge clk_i) disable iff (!rst_n)
         (st_q.state == WWD_RUN && cfg_i.enable && !svc_pulse && expired) |=> st_q.state == WWD_FIRED;
   endproperty
   a_expire: assert property (p_expire) else $error("expired count did not fire");

   property p_irq;
      @(posedge clk_i) disable iff (!rst_n)
         (st_q.state == WWD_FIRED && cfg_i.irq_en) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing after timeout");

   property p_rst;
      @(posedge clk_i) disable iff (!rst_n)
         sys_rst_o |-> $past(st_q.state) == WWD_FIRED && $past(cfg_i.rst_en);
   endproperty
   a_rst: assert property (p_rst) else $error("reset request without cause");

   property p_restart;
      @(posedge clk_i) disable iff (!rst_n)
         (irq_o && !$past(irq_o)) || sys_rst_o |-> restart_o;
   endproperty
   a_restart: assert property (p_restart) else $error("response without restart");

   property p_early;
      @(posedge clk_i) disable iff (!rst_n)
         (st_q.state == WWD_RUN && cfg_i.enable && svc_pulse && too_early)
            |=> early_o ##1 restart_o == (cfg_i.irq_en | cfg_i.rst_en);
   endproperty
   a_early: assert property (p_early) else $error("early service not punished");

   property p_service;
      @(posedge clk_i) disable iff (!rst_n)
         (st_q.state == WWD_RUN && cfg_i.enable && svc_pulse && !too_early) |=> count_o == CNT_RST;
   endproperty
   a_service: assert property (p_service) else $error("valid service did not restart count");

   property p_count;
      @(posedge clk_i) disable iff (!rst_n)
         (st_q.state == WWD_RUN && cfg_i.enable && !svc_pulse && !expired && tick)
            |=> count_o == $past(count_o) + 32'h0000_0001;
   endproperty
   a_count: assert property (p_count) else $error("count did not advance on tick");

   property p_wake;
      @(posedge clk_i) disable iff (!rst_n)
         wake_o |-> irq_o && $past(lpm_i || upm_i);
   endproperty
   a_wake: assert property (p_wake) else $error("wake without interrupt");

   property p_upm;
      @(posedge clk_i) disable iff (!rst_n)
         (!LOW_POWER_INST && wake_o) |-> $past(lpm_i);
   endproperty
   a_upm: assert property (p_upm) else $error("primary woke from upm");

   // a clear only loses when a new interrupt is raised in the same cycle
   property p_irq_clear;
      @(posedge clk_i) disable iff (!rst_n)
         (irq_o && irq_clr_i && !(st_q.state == WWD_FIRED && cfg_i.irq_en)) |=> !irq_o;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

   property p_restart_pulse;
      @(posedge clk_i) disable iff (!rst_n)
         restart_o |=> !restart_o;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart held longer than one cycle");

   property p_early_win;
      @(posedge clk_i) disable iff (!rst_n)
         early_o |-> $past(cfg_i.win_enable) && $past(st_q.count) < $past(cfg_i.win_open);
   endproperty
   a_early_win: assert property (p_early_win) else $error("early flag outside a closed window");

   property p_hold;
      @(posedge clk_i) disable iff (!rst_n)
         (st_q.state == WWD_RUN && cfg_i.enable && !svc_pulse && !expired && !tick)
            |=> count_o == $past(count_o);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved without a tick");

   property p_off;
      @(posedge clk_i) disable iff (!rst_n)
         st_q.state == WWD_OFF |=> count_o == CNT_RST;
   endproperty
   a_off: assert property (p_off) else $error("count not cleared while off");

endmodule

// ===== dv/windowed_watchdog_timer_test.sv
`timescale 1ns/1ps
module windowed_watchdog_timer_test
   import wwd_pkg::*;
;
   typedef struct packed {logic irq; logic srst; logic wake; logic lwake; logic early;} wwd_note_s;
   logic            clk_i = 0;
   logic            arst_n = 0;
   wwd_cfg_s        cfg = '0;
   logic            svc = 0, clr = 0, lpm = 0, upm = 0;
   logic            irq, srst, wake, rst_o, early, lp_wake;
   logic [CNT_W-1:0] cnt, c0;
   wwd_note_s       notes[$];
   int              miscompares = 0, check_count = 0;
   logic [31:0]     rng = 32'h0000_0f98;
   // {irq_en, rst_en, lpm, upm, early service}
   logic [4:0]      tbl [5] = '{5'b10000, 5'b01000, 5'b11100, 5'b10010, 5'b01001};

   wwd_top uut (.clk_i(clk_i), .arst_n_i(arst_n), .cfg_i(cfg), .service_i(svc), .irq_clr_i(clr),
      .lpm_i(lpm), .upm_i(upm), .irq_o(irq), .sys_rst_o(srst), .wake_o(wake), .restart_o(rst_o),
      .early_o(early), .count_o(cnt));

   // low-power instance on the same stimulus, watched only for its wake request
   wwd_top #(.LOW_POWER_INST(1'b1)) uut_lp (.clk_i(clk_i), .arst_n_i(arst_n), .cfg_i(cfg), .service_i(svc),
      .irq_clr_i(clr), .lpm_i(lpm), .upm_i(upm), .irq_o(), .sys_rst_o(), .wake_o(lp_wake), .restart_o(),
      .early_o(), .count_o());

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // drive one timeout or early-service failure, note the expected responses
   task automatic fire(input logic [4:0] t);
      int k;
      rng = xs(rng);
      @(negedge clk_i);
      cfg = '{1'b1, t[0], t[4], t[3], {1'b0, rng[1:0]}, 32'h10 + rng[7:2], 32'h0e + rng[7:2]};
      lpm = t[2];
      upm = t[1];
      notes.push_back('{t[4], t[3], t[4] & t[2], t[4] & (t[2] | t[1]), t[0]});
      if (t[0]) begin
         repeat (2) @(negedge clk_i);
         svc = 1; // before the window opens
         @(negedge clk_i);
         svc = 0;
      end
      for (k = 0; k < 4000 && rst_o !== 1'b1; k++) @(negedge clk_i);
      check("restart", rst_o, 1);
      repeat (3) @(negedge clk_i);
      cfg.enable = 0;
      clr = 1;
      @(negedge clk_i);
      clr = 0;
      @(negedge clk_i);
      check("irq cleared", irq, 0);
      $display("test fire %b done", t);
   endtask

   // outputs watcher: pops one note per restart pulse
   initial begin : watch
      logic e, i, s, w, l;
      wwd_note_s n;
      e = 0;
      forever begin
         @(posedge clk_i);
         if (early === 1'b1) e = 1;
         if (rst_o === 1'b1) begin
            i = irq;
            s = srst;
            w = wake;
            l = lp_wake;
            @(posedge clk_i);
            w = w | wake;
            l = l | lp_wake;
            if (notes.size() == 0) check("unexpected restart", 1, 0);
            else begin
               n = notes.pop_front();
               check("irq", i, n.irq);
               check("sys_rst", s, n.srst);
               check("wake", w, n.wake);
               check("low-power wake", l, n.lwake);
               check("early", e, n.early);
            end
            e = 0;
         end
      end
   end

   initial forever #4 clk_i = ~clk_i;

   // watchdog: whole run is well under 20000 cycles
   initial begin
      #160us;
      miscompares++;
      tally_and_finish();
   end

   initial begin : main
      int s;
      repeat (3) @(negedge clk_i);
      arst_n = 1;
      repeat (3) @(negedge clk_i);
      // prescaler rate: k periods give exactly k increments
      for (int j = 0; j < 4; j++) begin
         rng = xs(rng);
         s = rng[1:0];
         cfg = '{1'b1, 1'b0, 1'b1, 1'b0, rng[2:0] & 3'h3, 32'hffff_ffff, 32'h0};
         repeat ((1 << s) * 3 + 6) @(negedge clk_i);
         c0 = cnt;
         repeat ((1 << s) * 5) @(negedge clk_i);
         check("ticks", cnt - c0, 5);
         cfg.enable = 0;
         @(negedge clk_i);
      end
      $display("test prescaler done");
      // serviced inside the window: no timeout may occur
      cfg = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 32'h28, 32'h0a};
      repeat (6) begin
         repeat (25) @(negedge clk_i);
         svc = 1;
         @(negedge clk_i);
         svc = 0;
      end
      check("serviced count", cnt < 32'h28, 1);
      cfg.enable = 0;
      repeat (4) @(negedge clk_i);
      $display("test service done");
      foreach (tbl[i]) fire(tbl[i]);
      repeat (4) @(negedge clk_i);
      check("notes left", notes.size(), 0);
      tally_and_finish();
   end
endmodule
